/* tb/rbim_peer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rbim_peer_model (
	input wire logic clk_i,
	output logic valid_o,
	output logic [3:0] src_o,
	output logic [31:0] bits_o
);
	initial valid_o = 1'b0;
	initial src_o = 4'h0;
	initial bits_o = 32'h0;
	// One message; bit n carries outbound bit n, lines scrambled after
	task send(input logic [3:0] src, input logic [31:0] bits);
		@(negedge clk_i);
		valid_o = 1'b1;
		src_o = src;
		bits_o = bits;
		@(negedge clk_i);
		valid_o = 1'b0;
		src_o = ~src;
		bits_o = ~bits;
	endtask
endmodule
`default_nettype wire

/* tb/rbim_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rbim_check (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic MSG_VALID_I,
	input wire logic [3:0] MSG_SRC_I,
	input wire logic [31:0] MSG_BITS_I,
	input wire logic [127:0] SOURCE_NODE_SELECT_I,
	input wire logic [159:0] SOURCE_BIT_SELECT_I,
	input wire logic [63:0] FALLBACK_POLICY_I,
	input wire logic [223:0] OUT_SOURCE_SELECT_I,
	input wire logic [63:0] OPERAND_I,
	input wire logic [31:0] DIRECT_IN_O,
	input wire logic [31:0] DIRECT_OUT_O,
	input wire logic [15:0] PEER_ONLINE_O
);
	// Settings of input 0 and output 0
	wire logic [3:0] s = SOURCE_NODE_SELECT_I[3:0];
	wire logic [1:0] p = FALLBACK_POLICY_I[1:0];
	wire logic [6:0] o = OUT_SOURCE_SELECT_I[6:0];
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	peer_up_a: assert property (MSG_VALID_I |=> PEER_ONLINE_O[$past(MSG_SRC_I)])
		else $error("peer not online");
	in_track_a: assert property (MSG_VALID_I && MSG_SRC_I == s |=> ##1
		DIRECT_IN_O[0] == $past(MSG_BITS_I[SOURCE_BIT_SELECT_I[4:0]], 2)) else $error("track");
	fb_on_a: assert property (!PEER_ONLINE_O[s] && p == 2'h0 |=> DIRECT_IN_O[0])
		else $error("fallback on");
	fb_off_a: assert property (!PEER_ONLINE_O[s] && p == 2'h1 |=> !DIRECT_IN_O[0])
		else $error("fallback off");
	fb_hold_a: assert property (p[1] && !PEER_ONLINE_O[s] ##1 $stable(p)
		&& !PEER_ONLINE_O[s] |=> $stable(DIRECT_IN_O[0])) else $error("hold");
	up_hold_a: assert property ($rose(PEER_ONLINE_O[s]) |=> PEER_ONLINE_O[s] [*8])
		else $error("early drop");
	out_oper_a: assert property (!o[6] |=> DIRECT_OUT_O[0] == $past(OPERAND_I[o[5:0]]))
		else $error("operand");
	out_din_a: assert property (o[6:5] == 2'h2 |=>
		DIRECT_OUT_O[0] == $past(DIRECT_IN_O[o[4:0]])) else $error("bridge");
endmodule
bind rbim_top rbim_check chk_u (.*);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic CORE_CLK_I = 1'b0;
	logic RST_I = 1'b1;
	wire logic MSG_VALID_I;
	wire logic [3:0] MSG_SRC_I;
	wire logic [31:0] MSG_BITS_I;
	logic [127:0] SOURCE_NODE_SELECT_I = {{31{4'h5}}, 4'h2};
	logic [159:0] SOURCE_BIT_SELECT_I = 160'h0c;
	logic [63:0] FALLBACK_POLICY_I = 64'h3a;
	logic [223:0] OUT_SOURCE_SELECT_I = 224'h2007;
	logic [63:0] OPERAND_I = 64'h80;
	wire logic [31:0] DIRECT_IN_O;
	wire logic [31:0] DIRECT_OUT_O;
	wire logic [15:0] PEER_ONLINE_O;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	rbim_top #(.TIMEOUT_US(16'h0002)) dut_u (.*);
	rbim_peer_model peer_u (.clk_i(CORE_CLK_I), .valid_o(MSG_VALID_I), .src_o(MSG_SRC_I),
		.bits_o(MSG_BITS_I));
	initial forever #20 CORE_CLK_I = ~CORE_CLK_I;
	// Hang guard
	always @(posedge CORE_CLK_I) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			close_out;
		end
	end
	task chk(string n, logic s, logic e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %b got %b", n, e, s);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task t_start;
		repeat (2) @(negedge CORE_CLK_I);
		chk("din0", DIRECT_IN_O[0], 1'b1);
		chk("din1", DIRECT_IN_O[1], 1'b1);
		chk("din2", DIRECT_IN_O[2], 1'b0);
		chk("dout0", DIRECT_OUT_O[0], 1'b1);
		$display("t_start done");
	endtask
	task t_map;
		peer_u.send(4'h2, ~32'h1000);
		peer_u.send(4'h3, 32'h1000);
		repeat (3) @(negedge CORE_CLK_I);
		chk("din0", DIRECT_IN_O[0], 1'b0);
		chk("up3", PEER_ONLINE_O[3], 1'b1);
		peer_u.send(4'h2, 32'h1000);
		repeat (3) @(negedge CORE_CLK_I);
		chk("dout1", DIRECT_OUT_O[1], 1'b1);
		peer_u.send(4'h2, 32'h0);
		$display("t_map done");
	endtask
	task t_pol;
		for (int i = 0; i < 100 && PEER_ONLINE_O[2] !== 1'b0; i++)
			@(negedge CORE_CLK_I);
		chk("up2", PEER_ONLINE_O[2], 1'b0);
		for (int p = 0; p < 4; p++) begin
			FALLBACK_POLICY_I[1:0] = 2'(p);
			repeat (2) @(negedge CORE_CLK_I);
			chk("pol", DIRECT_IN_O[0], p == 0);
		end
		OUT_SOURCE_SELECT_I[6:0] = 7'h42;
		repeat (2) @(negedge CORE_CLK_I);
		chk("dout0", DIRECT_OUT_O[0], 1'b0);
		$display("t_pol done");
	endtask
	initial begin
		repeat (5) @(negedge CORE_CLK_I);
		RST_I = 1'b0;
		t_start;
		t_map;
		t_pol;
		close_out;
	end
endmodule
`default_nettype wire

/* verilog/rbim_peer_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module rbim_peer_timer
	import rbim_pkg::*;
#(
	parameter logic [RBIM_TMO_W-1:0] TIMEOUT_US = 16'(RBIM_TIMEOUT_US)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic hit_i,
	output logic online_o
);

	logic [RBIM_TMO_W-1:0] cnt_r;
	logic [RBIM_TMO_W-1:0] cnt_nxt;
	logic online_r;
	logic online_nxt;

	// Watchdog on silence; a message always wins over expiry
	always_comb begin
		cnt_nxt = cnt_r;
		online_nxt = online_r;
		if (hit_i) begin
			cnt_nxt = RBIM_TMO_RST; // R9
			online_nxt = 1'b1; // R9
		end else if (tick_i && online_r) begin
			if (cnt_r >= TIMEOUT_US - 16'h0001) begin
				online_nxt = 1'b0; // R9
				cnt_nxt = RBIM_TMO_RST;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end

	// State registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= RBIM_TMO_RST;
			online_r <= RBIM_ONLINE_RST;
		end else begin
			cnt_r <= cnt_nxt;
			online_r <= online_nxt;
		end
	end

	assign online_o = online_r;

endmodule
`default_nettype wire

/* verilog/rbim_pkg.sv */
// Functional notes
// R1: 32 inputs, each fed by one chosen peer
// R2: Bit select picks message bit; sender assigns position
// R3: Policy On: offline peer forces input high
// R4: Policy Off: offline peer forces input low
// R5: Hold/high: keep last value, high if none
// R6: Hold/low: keep last value, low if none
// R7: Each output follows its selected internal operand
// R8: Received inputs selectable as output sources (bridging)
// R9: Peer offline after timeout, online on message
`default_nettype none
package rbim_pkg;

	// Sizes of the mapper
	localparam int RBIM_NIN = 32;
	localparam int RBIM_NOUT = 32;
	localparam int RBIM_NPEER = 16;
	localparam int RBIM_NOPER = 64;
	localparam int RBIM_PEER_W = 4;
	localparam int RBIM_BIT_W = 5;
	localparam int RBIM_POL_W = 2;
	localparam int RBIM_OSEL_W = 7;
	localparam int RBIM_SRC_N = RBIM_NOPER + RBIM_NIN;

	// Timing: one microsecond tick from the core clock
	localparam int RBIM_CLK_HZ = 25_000_000;
	localparam int RBIM_TICK_NS = 1000;
	localparam int RBIM_TICK_CYC = (RBIM_TICK_NS * (RBIM_CLK_HZ / 1_000_000)) / 1000;
	localparam logic [4:0] RBIM_TICK_LAST = 5'(RBIM_TICK_CYC - 1);
	localparam logic [4:0] RBIM_TICK_RST = 5'h00;

	// Silence after which a peer counts as offline, in microseconds
	localparam int RBIM_TIMEOUT_US = 1000;
	localparam int RBIM_TMO_W = 16;
	localparam logic [15:0] RBIM_TMO_RST = 16'h0000;

	// Values after reset
	localparam logic RBIM_DIN_RST = 1'b0;
	localparam logic RBIM_DOUT_RST = 1'b0;
	localparam logic RBIM_KNOWN_RST = 1'b0;
	localparam logic RBIM_LAST_RST = 1'b0;
	localparam logic RBIM_ONLINE_RST = 1'b0;

	// Fallback policy of a direct input
	typedef enum logic [1:0] {
		RBIM_POL_ON,
		RBIM_POL_OFF,
		RBIM_POL_HOLD_ON,
		RBIM_POL_HOLD_OFF
	} rbim_policy_type;

endpackage
`default_nettype wire

/* verilog/rbim_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rbim_top
	import rbim_pkg::*;
#(
	parameter logic [RBIM_TMO_W-1:0] TIMEOUT_US = 16'(RBIM_TIMEOUT_US)
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Received message from the channel framer (same clock)
	input wire logic MSG_VALID_I,
	input wire logic [RBIM_PEER_W-1:0] MSG_SRC_I,
	input wire logic [RBIM_NIN-1:0] MSG_BITS_I,
	// Direct input settings, one field per input
	input wire logic [RBIM_NIN*RBIM_PEER_W-1:0] SOURCE_NODE_SELECT_I,
	input wire logic [RBIM_NIN*RBIM_BIT_W-1:0] SOURCE_BIT_SELECT_I,
	input wire logic [RBIM_NIN*RBIM_POL_W-1:0] FALLBACK_POLICY_I,
	// Direct output settings and internal operands
	input wire logic [RBIM_NOUT*RBIM_OSEL_W-1:0] OUT_SOURCE_SELECT_I,
	input wire logic [RBIM_NOPER-1:0] OPERAND_I,
	// Results
	output logic [RBIM_NIN-1:0] DIRECT_IN_O,
	output logic [RBIM_NOUT-1:0] DIRECT_OUT_O,
	output logic [RBIM_NPEER-1:0] PEER_ONLINE_O
);

	// Message from a given peer is present this cycle
	function automatic logic peer_hit(
		input logic valid,
		input logic [RBIM_PEER_W-1:0] src,
		input logic [RBIM_PEER_W-1:0] sel
	);
		peer_hit = valid && (src == sel);
	endfunction

	logic [4:0] tick_cnt_r;
	logic [4:0] tick_cnt_nxt;
	logic tick;
	logic [RBIM_NPEER-1:0] online;
	logic [RBIM_NIN-1:0] din_r;
	logic [RBIM_NIN-1:0] din_nxt;
	logic [RBIM_NIN-1:0] last_r;
	logic [RBIM_NIN-1:0] last_nxt;
	logic [RBIM_NIN-1:0] known_r;
	logic [RBIM_NIN-1:0] known_nxt;
	logic [RBIM_NOUT-1:0] dout_r;
	logic [RBIM_NOUT-1:0] dout_nxt;
	logic [RBIM_SRC_N-1:0] src_pool;

	// Microsecond tick divider
	always_comb begin
		tick = (tick_cnt_r == RBIM_TICK_LAST);
		if (tick) begin
			tick_cnt_nxt = RBIM_TICK_RST;
		end else begin
			tick_cnt_nxt = tick_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tick_cnt_r <= RBIM_TICK_RST;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// One liveness watchdog per peer
	genvar p;
	generate
		for (p = 0; p < RBIM_NPEER; p++) begin : g_peer
			rbim_peer_timer #(
				.TIMEOUT_US(TIMEOUT_US)
			) u_timer (
				.clk_i(CORE_CLK_I),
				.rst_i(RST_I),
				.tick_i(tick),
				.hit_i(peer_hit(MSG_VALID_I, MSG_SRC_I, RBIM_PEER_W'(p))), // R9
				.online_o(online[p])
			);
		end
	endgenerate

	// Per-input capture and fallback selection
	genvar i;
	generate
		for (i = 0; i < RBIM_NIN; i++) begin : g_din
			logic [RBIM_PEER_W-1:0] node_sel;
			logic [RBIM_BIT_W-1:0] bit_sel;
			rbim_policy_type policy;
			logic hit;
			logic peer_up;

			assign node_sel = SOURCE_NODE_SELECT_I[i*RBIM_PEER_W +: RBIM_PEER_W];
			assign bit_sel = SOURCE_BIT_SELECT_I[i*RBIM_BIT_W +: RBIM_BIT_W];
			assign policy = rbim_policy_type'(FALLBACK_POLICY_I[i*RBIM_POL_W +: RBIM_POL_W]);
			assign hit = peer_hit(MSG_VALID_I, MSG_SRC_I, node_sel); // R1
			assign peer_up = online[node_sel]; // R1

			// Latest bit from the chosen peer, and whether any arrived
			always_comb begin
				last_nxt[i] = last_r[i];
				known_nxt[i] = known_r[i];
				if (hit) begin
					last_nxt[i] = MSG_BITS_I[bit_sel]; // R2
					known_nxt[i] = 1'b1;
				end
				if (peer_up) begin
					din_nxt[i] = last_r[i];
				end else begin
					case (policy)
						RBIM_POL_ON: begin
							din_nxt[i] = 1'b1; // R3
						end
						RBIM_POL_OFF: begin
							din_nxt[i] = 1'b0; // R4
						end
						RBIM_POL_HOLD_ON: begin
							din_nxt[i] = known_r[i] ? last_r[i] : 1'b1; // R5
						end
						default: begin
							din_nxt[i] = known_r[i] ? last_r[i] : 1'b0; // R6
						end
					endcase
				end
			end
		end
	endgenerate

	// Input state registers
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			last_r <= {RBIM_NIN{RBIM_LAST_RST}};
			known_r <= {RBIM_NIN{RBIM_KNOWN_RST}};
			din_r <= {RBIM_NIN{RBIM_DIN_RST}};
		end else begin
			last_r <= last_nxt;
			known_r <= known_nxt;
			din_r <= din_nxt;
		end
	end

	// Output sources: operands low, received inputs above them
	assign src_pool = {din_r, OPERAND_I}; // R8

	genvar o;
	generate
		for (o = 0; o < RBIM_NOUT; o++) begin : g_dout
			logic [RBIM_OSEL_W-1:0] osel;

			assign osel = OUT_SOURCE_SELECT_I[o*RBIM_OSEL_W +: RBIM_OSEL_W];

			// Selects beyond the pool read low
			always_comb begin
				if (int'(osel) < RBIM_SRC_N) begin
					dout_nxt[o] = src_pool[osel]; // R7
				end else begin
					dout_nxt[o] = 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dout_r <= {RBIM_NOUT{RBIM_DOUT_RST}};
		end else begin
			dout_r <= dout_nxt;
		end
	end

	assign DIRECT_IN_O = din_r;
	assign DIRECT_OUT_O = dout_r;
	assign PEER_ONLINE_O = online;

endmodule
`default_nettype wire
